// ===== core/analog_reference_regulator_ctrl.sv
// Register bank for reference selection, sensor enable, sensor offset low bits and regulator control.
// Assumes a single-cycle special-function register port from the core, synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none

module analog_reference_regulator_ctrl #(
    parameter int ADDR_WIDTH = 8,
    parameter int DATA_WIDTH = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Factory offset low bits, caught while reset is held
    input wire logic [1:0] factorySensorOffset,
    // Special-function register port
    input wire logic [ADDR_WIDTH-1:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    input wire logic [DATA_WIDTH-1:0] sfrWdata,
    output logic [DATA_WIDTH-1:0] sfrRdata,
    // Core power status
    input wire logic stopMode,
    // Analog reference and sensor lines
    output logic refUseExtPin,
    output logic refUseVdd,
    output logic refUseRegulator,
    output logic sensorOn,
    // Regulator lines
    output logic regulatorOff,
    output logic otherResetsAllowed
);
    import arr_pkg::*;

    // The decode and bit layout are byte-wide only
    if (ADDR_WIDTH != 8 || DATA_WIDTH != 8) begin : g_width_check
        $error("analog_reference_regulator_ctrl supports only 8-bit address and data");
    end

    typedef struct packed {
        logic [1:0] offsetLow;
        logic regOverride;
        logic refSelect;
        logic sensorEnable;
        logic stopPowerConfig;
        logic regBypass;
        logic [7:0] rdata;
    } bank_t;

    bank_t bank_ff;
    bank_t nxt_bank;
    pwrState_t pwrState;

    arr_ctrl_if ctrl ();

    // Read value of each register; unused and unmapped bits come back as zero
    function automatic logic [7:0] readValue(input logic [7:0] addr, input bank_t b);
        logic [7:0] v;
        v = READ_ZERO;
        if (addr == ADDR_TEMP_OFFSET_LOW) begin
            v[OFFSET_LOW_MSB:OFFSET_LOW_LSB] = b.offsetLow;
            v[OFFSET_LOW_LSB-1:0] = OFFSET_LOW_UNUSED_READ;
        end else if (addr == ADDR_REFERENCE_CONTROL) begin
            // Bits 7:5 and 1:0 stay at zero
            v[REFCTL_OVERRIDE_BIT] = b.regOverride;
            v[REFCTL_SELECT_BIT] = b.refSelect;
            v[REFCTL_SENSOR_BIT] = b.sensorEnable;
        end else if (addr == ADDR_REGULATOR_CONTROL) begin
            v[REGCTL_STOPCFG_BIT] = b.stopPowerConfig;
            v[REGCTL_BYPASS_BIT] = b.regBypass;
        end
        return v;
    endfunction : readValue

    // Write decode; only the documented bits are stored
    always_comb begin
        nxt_bank = bank_ff;
        if (sfrWrite) begin
            if (sfrAddr == ADDR_TEMP_OFFSET_LOW) begin
                nxt_bank.offsetLow = sfrWdata[OFFSET_LOW_MSB:OFFSET_LOW_LSB];
            end else if (sfrAddr == ADDR_REFERENCE_CONTROL) begin
                nxt_bank.regOverride = sfrWdata[REFCTL_OVERRIDE_BIT];
                nxt_bank.refSelect = sfrWdata[REFCTL_SELECT_BIT];
                nxt_bank.sensorEnable = sfrWdata[REFCTL_SENSOR_BIT];
            end else if (sfrAddr == ADDR_REGULATOR_CONTROL) begin
                nxt_bank.stopPowerConfig = sfrWdata[REGCTL_STOPCFG_BIT];
                // Bypass is trusted to software, which must have an external supply
                nxt_bank.regBypass = sfrWdata[REGCTL_BYPASS_BIT];
            end
        end
        // Read data is captured so it stays put until the next read
        if (sfrRead) begin
            nxt_bank.rdata = readValue(sfrAddr, bank_ff);
        end
    end

    // State register; the factory bits are sampled throughout reset so they are valid at release
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            bank_ff.offsetLow <= factorySensorOffset;
            bank_ff.regOverride <= REFCTL_OVERRIDE_RESET;
            bank_ff.refSelect <= REFCTL_SELECT_RESET;
            bank_ff.sensorEnable <= REFCTL_SENSOR_RESET;
            bank_ff.stopPowerConfig <= REGCTL_STOPCFG_RESET;
            bank_ff.regBypass <= REGCTL_BYPASS_RESET;
            bank_ff.rdata <= READ_ZERO;
        end else begin
            bank_ff <= nxt_bank;
        end
    end

    // Fields toward the drive stage
    assign ctrl.regOverride = bank_ff.regOverride;
    assign ctrl.refSelect = bank_ff.refSelect;
    assign ctrl.sensorEnable = bank_ff.sensorEnable;
    assign ctrl.stopPowerConfig = bank_ff.stopPowerConfig;
    assign ctrl.regBypass = bank_ff.regBypass;
    assign ctrl.stopMode = stopMode;

    // Registered drive of the analog selects and regulator power
    arr_power_drive u_drive (
        .mclk(mclk),
        .reset_n(reset_n),
        .ctrl(ctrl),
        .refUseExtPin(refUseExtPin),
        .refUseVdd(refUseVdd),
        .refUseRegulator(refUseRegulator),
        .sensorOn(sensorOn),
        .regulatorOff(regulatorOff),
        .otherResetsAllowed(otherResetsAllowed),
        .pwrState(pwrState)
    );

    assign sfrRdata = bank_ff.rdata;

    // Checks on the bank and its drive stage
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    a_offlow_factory_bits: assert property (
        (sfrRead && sfrAddr == ADDR_TEMP_OFFSET_LOW && !sfrWrite)
            |=> (sfrRdata[7:6] == $past(bank_ff.offsetLow)))
        else $error("offset low read lost the stored bits");

    a_offlow_unused_zero: assert property (
        (sfrRead && sfrAddr == ADDR_TEMP_OFFSET_LOW) |=> (sfrRdata[5:0] == 6'h00))
        else $error("offset low unused bits not zero");

    a_refctl_high_zero: assert property (
        (sfrRead && sfrAddr == ADDR_REFERENCE_CONTROL) |=> (sfrRdata[7:5] == 3'h0))
        else $error("reference control bits 7:5 not zero");

    a_refctl_low_zero: assert property (
        (sfrRead && sfrAddr == ADDR_REFERENCE_CONTROL) |=> (sfrRdata[1:0] == 2'h0))
        else $error("reference control bits 1:0 not zero");

    a_override_wins: assert property (
        bank_ff.regOverride |=> (refUseRegulator && !refUseVdd && !refUseExtPin))
        else $error("override did not force the regulator reference");

    a_select_decides: assert property (
        !bank_ff.regOverride |=> (!refUseRegulator && refUseVdd == $past(bank_ff.refSelect)
            && refUseExtPin == !$past(bank_ff.refSelect)))
        else $error("reference select not followed");

    a_sensor_follows: assert property (
        (sfrWrite && sfrAddr == ADDR_REFERENCE_CONTROL) ##1 !sfrWrite
            |=> (sensorOn == $past(sfrWdata[2], 2)))
        else $error("sensor enable not applied two edges after write");

    a_stop_keeps_on: assert property (
        (pwrState == PWR_RUN && stopMode && !bank_ff.stopPowerConfig)
            |=> (otherResetsAllowed && pwrState == PWR_STOP_ON))
        else $error("regulator shut down with stop config clear");

    a_stop_shuts_down: assert property (
        (pwrState == PWR_RUN && stopMode && bank_ff.stopPowerConfig)
            |=> (regulatorOff && !otherResetsAllowed) [*1] ##0 (pwrState == PWR_STOP_OFF))
        else $error("regulator not shut down in stop");

    a_reset_values: assert property (
        $rose(reset_n) |-> (!bank_ff.regOverride && !bank_ff.refSelect && !bank_ff.sensorEnable
            && refUseExtPin && !sensorOn))
        else $error("reference control not at reset value");

    a_stopcfg_readback: assert property (
        (sfrWrite && sfrAddr == ADDR_REGULATOR_CONTROL) ##1 (sfrRead && !sfrWrite
            && sfrAddr == ADDR_REGULATOR_CONTROL)
            |=> (sfrRdata[7] == $past(sfrWdata[7], 2) && sfrRdata[5:0] == 6'h00))
        else $error("stop config bit not stored in bit 7");

    a_bypass_off: assert property (
        bank_ff.regBypass |=> regulatorOff)
        else $error("bypass did not turn the regulator off");

    a_select_onehot: assert property (
        $onehot({refUseExtPin, refUseVdd, refUseRegulator}))
        else $error("reference select lines not one-hot");

    // Stored fields move only on a write to their own register; a stray decode would show here first
    a_offlow_write_kept: assert property (
        (sfrWrite && sfrAddr == ADDR_TEMP_OFFSET_LOW)
            |=> (bank_ff.offsetLow == $past(sfrWdata[7:6])))
        else $error("offset low write not stored");

    a_offlow_only_write: assert property (
        !(sfrWrite && sfrAddr == ADDR_TEMP_OFFSET_LOW) |=> $stable(bank_ff.offsetLow))
        else $error("offset low changed without a write");

    a_offlow_reset_load: assert property (
        $rose(reset_n) |-> (bank_ff.offsetLow == $past(factorySensorOffset)))
        else $error("factory offset bits not caught in reset");

    a_refctl_write_kept: assert property (
        (sfrWrite && sfrAddr == ADDR_REFERENCE_CONTROL)
            |=> ({bank_ff.regOverride, bank_ff.refSelect, bank_ff.sensorEnable} == $past(sfrWdata[4:2])))
        else $error("reference control write not stored");

    a_refctl_only_write: assert property (
        !(sfrWrite && sfrAddr == ADDR_REFERENCE_CONTROL)
            |=> $stable({bank_ff.regOverride, bank_ff.refSelect, bank_ff.sensorEnable}))
        else $error("reference control changed without a write");

    a_refctl_readback: assert property (
        (sfrRead && sfrAddr == ADDR_REFERENCE_CONTROL)
            |=> (sfrRdata[4:2] == $past({bank_ff.regOverride, bank_ff.refSelect, bank_ff.sensorEnable})))
        else $error("reference control read lost stored bits");

    a_regctl_write_kept: assert property (
        (sfrWrite && sfrAddr == ADDR_REGULATOR_CONTROL)
            |=> ({bank_ff.stopPowerConfig, bank_ff.regBypass} == $past(sfrWdata[7:6])))
        else $error("regulator control write not stored");

    a_regctl_only_write: assert property (
        !(sfrWrite && sfrAddr == ADDR_REGULATOR_CONTROL)
            |=> $stable({bank_ff.stopPowerConfig, bank_ff.regBypass}))
        else $error("regulator control changed without a write");

    a_regctl_readback: assert property (
        (sfrRead && sfrAddr == ADDR_REGULATOR_CONTROL)
            |=> (sfrRdata == {$past(bank_ff.stopPowerConfig), $past(bank_ff.regBypass), 6'h00}))
        else $error("regulator control read wrong");

    // Read data is a register: software may sample it late, so it moves only when a read is taken
    a_rdata_holds: assert property (
        !sfrRead |=> $stable(sfrRdata))
        else $error("read data moved without a read");

    a_unmapped_zero: assert property (
        (sfrRead && sfrAddr != ADDR_TEMP_OFFSET_LOW && sfrAddr != ADDR_REFERENCE_CONTROL
            && sfrAddr != ADDR_REGULATOR_CONTROL) |=> (sfrRdata == 8'h00))
        else $error("unmapped address did not read zero");

    // Drive stage follows the stored fields one edge later
    // The extra edge costs latency but keeps the analog lines free of decode glitches
    a_sensor_tracks: assert property (
        1'h1 |=> (sensorOn == $past(bank_ff.sensorEnable)))
        else $error("sensor line does not follow its field");

    a_regoff_tracks: assert property (
        1'h1 |=> (regulatorOff == ($past(bank_ff.regBypass) || pwrState == PWR_STOP_OFF)))
        else $error("regulator off line does not follow bypass and stop state");

    a_resets_tracks: assert property (
        otherResetsAllowed == (pwrState != PWR_STOP_OFF))
        else $error("reset permission does not match power state");

    // Stop state is frozen at entry; only the end of stop moves it, whatever software writes meanwhile
    a_pwr_onehot: assert property (
        $onehot(pwrState))
        else $error("power state not one-hot");

    a_stop_on_holds: assert property (
        (pwrState == PWR_STOP_ON && stopMode) |=> (pwrState == PWR_STOP_ON && otherResetsAllowed))
        else $error("kept-on stop state left while stop held");

    a_stop_off_holds: assert property (
        (pwrState == PWR_STOP_OFF && stopMode) |=> (pwrState == PWR_STOP_OFF && regulatorOff))
        else $error("shut-down stop state left while stop held");

    a_stop_exit: assert property (
        (pwrState != PWR_RUN && !stopMode) |=> (pwrState == PWR_RUN && otherResetsAllowed))
        else $error("stop state not left after stop ended");

    a_run_no_shutdown: assert property (
        (pwrState == PWR_RUN && !stopMode) |=> (pwrState == PWR_RUN))
        else $error("power state left run without stop");
endmodule : analog_reference_regulator_ctrl
`default_nettype wire

// ===== core/arr_pkg.sv
// Constants shared by the reference and regulator control block and its drive stage.
// Assumes an 8-bit special-function register space with 8-bit addresses.
package arr_pkg;
    // Register addresses in the special-function register space
    localparam logic [7:0] ADDR_TEMP_OFFSET_LOW = 8'ha2;
    localparam logic [7:0] ADDR_REFERENCE_CONTROL = 8'hd1;
    localparam logic [7:0] ADDR_REGULATOR_CONTROL = 8'hc7;

    // Offset low byte: two stored bits at the top
    localparam int OFFSET_LOW_MSB = 7;
    localparam int OFFSET_LOW_LSB = 6;
    localparam logic [5:0] OFFSET_LOW_UNUSED_READ = 6'h00;

    // Reference control fields
    localparam int REFCTL_OVERRIDE_BIT = 4;
    localparam int REFCTL_SELECT_BIT = 3;
    localparam int REFCTL_SENSOR_BIT = 2;
    localparam logic REFCTL_OVERRIDE_RESET = 1'h0;
    localparam logic REFCTL_SELECT_RESET = 1'h0;
    localparam logic REFCTL_SENSOR_RESET = 1'h0;

    // Regulator control fields
    localparam int REGCTL_STOPCFG_BIT = 7;
    localparam int REGCTL_BYPASS_BIT = 6;
    localparam logic REGCTL_STOPCFG_RESET = 1'h0;
    localparam logic REGCTL_BYPASS_RESET = 1'h0;

    // Value returned for unused bits and unmapped addresses
    localparam logic [7:0] READ_ZERO = 8'h00;

    // Power state of the regulator around stop mode
    typedef enum logic [2:0] {
        PWR_RUN = 3'b001,
        PWR_STOP_ON = 3'b010,
        PWR_STOP_OFF = 3'b100
    } pwrState_t;
endpackage : arr_pkg

// ===== core/arr_ctrl_if.sv
// Interface carrying stored control fields from the register bank to the drive stage.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface arr_ctrl_if;
    logic regOverride;
    logic refSelect;
    logic sensorEnable;
    logic stopPowerConfig;
    logic regBypass;
    logic stopMode;

    // Register bank side
    modport bank (
        output regOverride,
        output refSelect,
        output sensorEnable,
        output stopPowerConfig,
        output regBypass,
        output stopMode
    );

    // Drive stage side
    modport drive (
        input regOverride,
        input refSelect,
        input sensorEnable,
        input stopPowerConfig,
        input regBypass,
        input stopMode
    );
endinterface : arr_ctrl_if
`default_nettype wire

// ===== core/arr_power_drive.sv
// Drive stage: turns stored control fields into registered analog select and power lines.
// Assumes fields are stable flip-flop outputs on the same clock; reset is synchronous.
`timescale 1ns/1ps
`default_nettype none
module arr_power_drive (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Control fields
    arr_ctrl_if.drive ctrl,
    // Analog lines
    output logic refUseExtPin,
    output logic refUseVdd,
    output logic refUseRegulator,
    output logic sensorOn,
    output logic regulatorOff,
    output logic otherResetsAllowed,
    output arr_pkg::pwrState_t pwrState
);
    import arr_pkg::*;

    typedef struct packed {
        pwrState_t pwr;
        logic ext;
        logic vdd;
        logic reg_;
        logic sensor;
        logic regOff;
        logic resetsOk;
    } drive_t;

    drive_t drive_ff;
    drive_t nxt_drive;

    // Registered one-hot select avoids glitches while the mux inputs settle
    always_comb begin
        nxt_drive = drive_ff;
        nxt_drive.reg_ = ctrl.regOverride;
        nxt_drive.vdd = !ctrl.regOverride && ctrl.refSelect;
        nxt_drive.ext = !ctrl.regOverride && !ctrl.refSelect;
        nxt_drive.sensor = ctrl.sensorEnable;
        case (drive_ff.pwr)
            PWR_RUN: begin
                if (ctrl.stopMode) begin
                    // Configuration is frozen at stop entry
                    nxt_drive.pwr = ctrl.stopPowerConfig ? PWR_STOP_OFF : PWR_STOP_ON;
                end
            end
            PWR_STOP_ON: begin
                if (!ctrl.stopMode) begin
                    nxt_drive.pwr = PWR_RUN;
                end
            end
            PWR_STOP_OFF: begin
                if (!ctrl.stopMode) begin
                    nxt_drive.pwr = PWR_RUN;
                end
            end
            default: begin
                nxt_drive.pwr = PWR_RUN;
            end
        endcase
        // Regulator off in bypass or in a shut-down stop; only the pin reset survives the latter
        nxt_drive.regOff = ctrl.regBypass || (nxt_drive.pwr == PWR_STOP_OFF);
        nxt_drive.resetsOk = (nxt_drive.pwr != PWR_STOP_OFF);
    end

    // State register
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            drive_ff <= '{pwr: PWR_RUN, ext: 1'h1, vdd: 1'h0, reg_: 1'h0, sensor: 1'h0,
                          regOff: 1'h0, resetsOk: 1'h1};
        end else begin
            drive_ff <= nxt_drive;
        end
    end

    assign refUseExtPin = drive_ff.ext;
    assign refUseVdd = drive_ff.vdd;
    assign refUseRegulator = drive_ff.reg_;
    assign sensorOn = drive_ff.sensor;
    assign regulatorOff = drive_ff.regOff;
    assign otherResetsAllowed = drive_ff.resetsOk;
    assign pwrState = drive_ff.pwr;
endmodule : arr_power_drive
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench for the reference and regulator control register bank.
// Assumes the bank's single-cycle register port; all inputs change on the falling edge of mclk.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import arr_pkg::*;

    // Stimulus and observed lines
    logic mclk;
    logic reset_n;
    logic [1:0] factorySensorOffset;
    logic [7:0] sfrAddr;
    logic sfrWrite;
    logic sfrRead;
    logic [7:0] sfrWdata;
    logic [7:0] sfrRdata;
    logic stopMode;
    logic refUseExtPin;
    logic refUseVdd;
    logic refUseRegulator;
    logic sensorOn;
    logic regulatorOff;
    logic otherResetsAllowed;
    int errorCnt;
    int checks;
    int cycles = 0;
    localparam int CYCLE_LIMIT = 5000;

    analog_reference_regulator_ctrl #(.ADDR_WIDTH(8), .DATA_WIDTH(8)) i_analog_reference_regulator_ctrl (
        .mclk(mclk),
        .reset_n(reset_n),
        .factorySensorOffset(factorySensorOffset),
        .sfrAddr(sfrAddr),
        .sfrWrite(sfrWrite),
        .sfrRead(sfrRead),
        .sfrWdata(sfrWdata),
        .sfrRdata(sfrRdata),
        .stopMode(stopMode),
        .refUseExtPin(refUseExtPin),
        .refUseVdd(refUseVdd),
        .refUseRegulator(refUseRegulator),
        .sensorOn(sensorOn),
        .regulatorOff(regulatorOff),
        .otherResetsAllowed(otherResetsAllowed)
    );

    // Free-running 100 MHz clock
    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end

    // Hang guard: the tests need about a hundred cycles, so the ceiling is generous
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == CYCLE_LIMIT) begin
            errorCnt++;
            conclude();
        end
    end

    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            errorCnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk8

    task automatic chk1(input string name, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            errorCnt++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask : chk1

    // One write pulse; request held across the sampling edge
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge mclk);
        sfrAddr = addr;
        sfrWdata = data;
        sfrWrite = 1'h1;
        @(negedge mclk);
        sfrWrite = 1'h0;
    endtask : wr

    // One read pulse; data is settled one edge after the read edge
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp, input string name);
        @(negedge mclk);
        sfrAddr = addr;
        sfrRead = 1'h1;
        @(negedge mclk);
        sfrRead = 1'h0;
        chk8(name, exp, sfrRdata);
    endtask : rd

    // Write, then read the same register in the very next cycle
    task automatic wrRd(input logic [7:0] addr, input logic [7:0] data, input logic [7:0] exp,
                        input string name);
        wr(addr, data);
        sfrRead = 1'h1;
        @(negedge mclk);
        sfrRead = 1'h0;
        chk8(name, exp, sfrRdata);
    endtask : wrRd

    // Reference selects and sensor line, checked together since the selects must stay one-hot
    task automatic chkRef(input logic ext, input logic vdd, input logic reg_, input logic sen);
        chk1("refUseExtPin", ext, refUseExtPin);
        chk1("refUseVdd", vdd, refUseVdd);
        chk1("refUseRegulator", reg_, refUseRegulator);
        chk1("sensorOn", sen, sensorOn);
    endtask : chkRef

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, errorCnt);
        if (errorCnt == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    // Main sequence
    initial begin
        logic [7:0] d;
        logic ov;
        logic sel;
        logic sen;
        errorCnt = 0;
        checks = 0;
        reset_n = 1'h0;
        factorySensorOffset = 2'h2;
        sfrAddr = 8'h00;
        sfrWrite = 1'h0;
        sfrRead = 1'h0;
        sfrWdata = 8'h00;
        stopMode = 1'h0;
        repeat (16) @(negedge mclk);
        reset_n = 1'h1;
        // Offset bits are caught during reset only; a later change must not show
        factorySensorOffset = 2'h1;

        // Reset values
        chkRef(1'h1, 1'h0, 1'h0, 1'h0);
        chk1("regulatorOff", 1'h0, regulatorOff);
        chk1("otherResetsAllowed", 1'h1, otherResetsAllowed);
        rd(ADDR_REFERENCE_CONTROL, 8'h00, "reference_control reset");
        rd(ADDR_REGULATOR_CONTROL, 8'h00, "regulator_control reset");
        rd(ADDR_TEMP_OFFSET_LOW, 8'h80, "temp_offset_low reset");
        $display("test reset done");

        // Offset low: top two bits stored, the rest read zero
        wr(ADDR_TEMP_OFFSET_LOW, 8'h7f);
        rd(ADDR_TEMP_OFFSET_LOW, 8'h40, "temp_offset_low 7f");
        wr(ADDR_TEMP_OFFSET_LOW, 8'hbf);
        rd(ADDR_TEMP_OFFSET_LOW, 8'h80, "temp_offset_low bf");
        $display("test offset done");

        // Every override/select pair, with unused bits written as ones
        for (int i = 0; i < 4; i++) begin
            ov = i[1];
            sel = i[0];
            sen = i[1] ^ i[0];
            wr(ADDR_REFERENCE_CONTROL, {3'h7, ov, sel, sen, 2'h3});
            @(negedge mclk);
            chkRef(~ov & ~sel, ~ov & sel, ov, sen);
            rd(ADDR_REFERENCE_CONTROL, {3'h0, ov, sel, sen, 2'h0}, "reference_control");
        end
        wr(ADDR_REFERENCE_CONTROL, 8'h00);
        @(negedge mclk);
        chkRef(1'h1, 1'h0, 1'h0, 1'h0);
        $display("test reference done");

        // Regulator control fields, reserved bits written as ones
        for (int i = 0; i < 4; i++) begin
            d = {i[1], i[0], 6'h3f};
            wr(ADDR_REGULATOR_CONTROL, d); // bypass set only as if an external supply feeds the core
            rd(ADDR_REGULATOR_CONTROL, {i[1], i[0], 6'h00}, "regulator_control");
            chk1("regulatorOff bypass", i[0], regulatorOff);
        end
        wrRd(ADDR_REGULATOR_CONTROL, 8'hbf, 8'h80, "regulator_control back to back");
        chk1("regulatorOff bypass clear", 1'h0, regulatorOff);
        $display("test regulator done");

        // Stop with regulator kept on, then with it shut down
        for (int s = 0; s < 2; s++) begin
            wr(ADDR_REGULATOR_CONTROL, {s[0], 7'h00});
            @(negedge mclk);
            stopMode = 1'h1;
            repeat (3) @(negedge mclk);
            chk1("regulatorOff stop", s[0], regulatorOff);
            chk1("otherResetsAllowed stop", ~s[0], otherResetsAllowed);
            stopMode = 1'h0;
            repeat (3) @(negedge mclk);
            chk1("regulatorOff run", 1'h0, regulatorOff);
            chk1("otherResetsAllowed run", 1'h1, otherResetsAllowed);
        end
        $display("test stop done");

        // Unmapped address: write ignored, read zero, reference_control untouched
        wr(8'h00, 8'h55);
        rd(8'h00, READ_ZERO, "unmapped 00");
        rd(ADDR_REFERENCE_CONTROL, 8'h00, "reference_control after unmapped");
        $display("test unmapped done");
        conclude();
    end
endmodule : testbench
`default_nettype wire
